// ### design/rbc_path.sv
// Purpose: Registers the analog switch and bias controls from the control bits.
// Assumes: Control bits come from logic on the same clock.
// Notes:   Buffer enable wins over bypass so the switch never shorts the buffer.
`timescale 1ns/1ps
`include "rbc_map.svh"

module rbc_path
  import rbc_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // Control bits.
  input  wire rbc_ctrl_t cfg,
  // Analog controls.
  output rbc_ana_t       ana
);

  rbc_ana_t ana_d;
  rbc_ana_t ana_q;

  // Switch and bias decode.
  assign ana_d.buf_en      = cfg.buffer_on_bit;
  assign ana_d.sw_close    = cfg.buffer_bypass_bit & ~cfg.buffer_on_bit;
  assign ana_d.hiz_en      = cfg.high_impedance_input_bit;
  assign ana_d.boost_en    = cfg.buffer_boost_bit & cfg.buffer_on_bit;
  assign ana_d.ext_isolate = cfg.buffer_on_bit | cfg.buffer_bypass_bit;

  // Output flops; reset leaves everything off and the switch open.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ana_q <= '0;
    end else begin
      ana_q <= ana_d;
    end
  end

  assign ana = ana_q;

  // A live buffer output is never tied back to its input pin.
  AST_NO_SHORT: assert property (@(posedge clk_sys) disable iff (rst)
    !(ana_q.buf_en && ana_q.sw_close)) else $error("Buffer on with bypass closed.");

endmodule // rbc_path

// ### design/rbc_top.sv
// Purpose: Reference buffer control with an APB register slave.
// Assumes: clk_sys at 10 MHz, synchronous active-high reset, APB from the same clock.
// Notes:   Status shows the analog path and whether the buffer has settled.
// How it works
// - Buffer off after power-up and every reset.
// - Power-up clears the buffer enable bit.
// - Enable bit starts buffer charging reference node.
// - Bypass without buffer closes the bypass switch.
// - Boost raises buffer current, faster charging.
// - Buffer in use isolates reference node externally.
`timescale 1ns/1ps
`include "rbc_map.svh"

module rbc_top
  import rbc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog reference path controls.
  output logic             buf_enable,
  output logic             bypass_switch_close,
  output logic             hiz_enable,
  output logic             boost_enable,
  output logic             ref_isolate,
  // Buffer settled flag.
  output logic             ref_ready
);

  // Turn-on waits, rounded up to whole clock cycles.
  localparam logic [9:0] TURNON_CYC =
    10'((`RBC_TURNON_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS);
  localparam logic [9:0] BOOST_CYC =
    10'((`RBC_BOOST_NS + `RBC_CLK_NS - 1) / `RBC_CLK_NS);

  rbc_ctrl_t  ctrl_q;
  rbc_ctrl_t  ctrl_d;
  rbc_ana_t   ana;
  rbc_state_t st_q;
  rbc_state_t st_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        ready_q;

  // APB decode; a request is answered one cycle after its setup phase.
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable & pready_q;
  wire logic sel_ctrl = (paddr == `RBC_CTRL_OFS);
  wire logic sel_stat = (paddr == `RBC_STAT_OFS);
  wire logic mapped   = sel_ctrl | sel_stat;
  wire logic wr_ctrl  = access & pwrite & sel_ctrl;

  // Status word built from the registered path state.
  wire logic [`RBC_STAT_W-1:0] stat_w = {
    ana.buf_en & ~ana.hiz_en,
    st_q == RBC_CHARGE,
    ready_q,
    ana.ext_isolate,
    ana.sw_close,
    ana.buf_en
  };

  // Read data mux; unmapped addresses read zero and answer with an error.
  assign prdata_d = sel_ctrl ? {28'h0000000, ctrl_q} :
                    sel_stat ? {26'h0, stat_w} : 32'h00000000;
  assign pslverr_d = ~mapped;

  // Next control value: only a completed write to the control word changes it.
  assign ctrl_d = wr_ctrl ? rbc_ctrl_t'(pwdata[`RBC_CTRL_W-1:0]) : ctrl_q;

  // Control register; reset returns the buffer to off with switch open.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= rbc_ctrl_t'(`RBC_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Bus answer flops; pready rises for the access phase only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & pslverr_d;
      prdata_q  <= (setup & ~pwrite) ? prdata_d : 32'h00000000;
    end
  end

  // The analog path registers its own controls from the control bits.
  rbc_path u_path (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cfg     (ctrl_q),
    .ana     (ana)
  );

  // Settling sequencer. Charging restarts from the full wait each time the
  // buffer is turned on, since the capacitor may have drooped while it was off.
  // Boost sampled at the enable edge picks the shorter wait; a later change of
  // boost does not rescale a charge already under way.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      RBC_OFF: begin
        if (ctrl_q.buffer_on_bit) begin
          st_d  = RBC_CHARGE;
          cnt_d = rbc_settle_cycles(ctrl_q.buffer_boost_bit, TURNON_CYC, BOOST_CYC);
        end
      end
      RBC_CHARGE: begin
        if (!ctrl_q.buffer_on_bit) begin
          st_d  = RBC_OFF;
          cnt_d = 10'h000;
        end else if (cnt_q == 10'h001) begin
          st_d  = RBC_READY;
          cnt_d = 10'h000;
        end else begin
          cnt_d = cnt_q - 10'h001;
        end
      end
      RBC_READY: begin
        if (!ctrl_q.buffer_on_bit) begin
          st_d = RBC_OFF;
        end
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q  <= RBC_OFF;
      cnt_q <= 10'h000;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // Settled flag is registered from the next state, so it rises together with the state and is a clean flop output.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (st_d == RBC_READY);
    end
  end

  // Output wiring; every analog control already comes from a flop in the path.
  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign buf_enable          = ana.buf_en;
  assign bypass_switch_close = ana.sw_close;
  assign hiz_enable          = ana.hiz_en;
  assign boost_enable        = ana.boost_en;
  assign ref_isolate         = ana.ext_isolate;
  assign ref_ready           = ready_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Reset always leaves the buffer off two edges later.
  AST_RST_OFF: assert property (disable iff (1'b0)
    rst |=> !ctrl_q.buffer_on_bit ##1 !buf_enable)
    else $error("Buffer not off after reset.");

  // The enable bit itself clears on reset.
  AST_RST_BIT: assert property (disable iff (1'b0)
    rst |=> (ctrl_q == rbc_ctrl_t'(`RBC_CTRL_RST)))
    else $error("Control bits not cleared by reset.");

  // Writing enable to a buffer that was off turns it on and starts charging; a repeated
  // enable while already settled must not restart the wait.
  AST_EN_START: assert property (
    (wr_ctrl && pwdata[`RBC_CTRL_ON] && !ctrl_q.buffer_on_bit) |=> ctrl_q.buffer_on_bit ##1
    (buf_enable && st_q == RBC_CHARGE))
    else $error("Enable write did not start the buffer.");

  // Bypass alone closes the switch one edge later.
  AST_BYPASS: assert property (
    (ctrl_q.buffer_bypass_bit && !ctrl_q.buffer_on_bit) |=>
    (bypass_switch_close && !buf_enable))
    else $error("Bypass switch not closed.");

  // Boost with the buffer on raises the drive and shortens the wait.
  AST_BOOST: assert property (
    (st_q == RBC_OFF && ctrl_q.buffer_on_bit && ctrl_q.buffer_boost_bit) |=>
    (cnt_q == BOOST_CYC) ##1 boost_enable)
    else $error("Boost did not take effect.");

  // Without boost the full turn-on wait is loaded.
  AST_SLOW: assert property (
    (st_q == RBC_OFF && ctrl_q.buffer_on_bit && !ctrl_q.buffer_boost_bit) |=>
    (cnt_q == TURNON_CYC))
    else $error("Turn-on wait not loaded.");

  // The last count of a charge ends in the settled state.
  AST_SETTLE: assert property (
    (st_q == RBC_CHARGE && cnt_q == 10'h001 && ctrl_q.buffer_on_bit) |=>
    (st_q == RBC_READY && ref_ready))
    else $error("Buffer did not settle on time.");

  // A running buffer is always isolated from outside circuitry.
  AST_ISOLATE: assert property (
    buf_enable |-> ref_isolate)
    else $error("Reference node not isolated.");

  // Every setup phase is answered in the next cycle.
  AST_APB_ANS: assert property (
    (psel && !penable) |=> pready)
    else $error("APB answer late.");

endmodule // rbc_top

// ### include/rbc_map.svh
// Purpose: Offsets, field positions, reset values and timing of the reference buffer control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only; included by bare name.
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH

// Register byte offsets.
`define RBC_CTRL_OFS     12'h000
`define RBC_STAT_OFS     12'h004

// Control register field positions.
`define RBC_CTRL_ON      0
`define RBC_CTRL_BYPASS  1
`define RBC_CTRL_HIZ     2
`define RBC_CTRL_BOOST   3
`define RBC_CTRL_W       4

// Control reset value: buffer off, switch open, high impedance off, boost off.
`define RBC_CTRL_RST     4'h0

// Status register field positions.
`define RBC_STAT_DRIVE   0
`define RBC_STAT_SWITCH  1
`define RBC_STAT_ISOL    2
`define RBC_STAT_READY   3
`define RBC_STAT_CHARGE  4
`define RBC_STAT_HIZMISS 5
`define RBC_STAT_W       6

// Clock period and buffer turn-on times, in nanoseconds.
`define RBC_CLK_NS       100
`define RBC_TURNON_NS    100000
`define RBC_BOOST_NS     25000

`endif

// ### include/rbc_pkg.sv
// Purpose: Types shared by the reference buffer control modules.
// Assumes: Numbers live in rbc_map.svh.
// Notes:   Structs are packed so they map straight onto register bits.
package rbc_pkg;

  // Software control bits, MSB first so bit 0 is the buffer enable.
  typedef struct packed {
    logic buffer_boost_bit;
    logic high_impedance_input_bit;
    logic buffer_bypass_bit;
    logic buffer_on_bit;
  } rbc_ctrl_t;

  // Controls driven into the analog reference path.
  typedef struct packed {
    logic buf_en;
    logic sw_close;
    logic hiz_en;
    logic boost_en;
    logic ext_isolate;
  } rbc_ana_t;

  // Buffer settling state.
  typedef enum logic [1:0] {
    RBC_OFF,
    RBC_CHARGE,
    RBC_READY
  } rbc_state_t;

  // Settling wait chosen by boost; boost charges the capacitor faster.
  function automatic logic [9:0] rbc_settle_cycles(input logic boost,
                                                   input logic [9:0] slow,
                                                   input logic [9:0] fast);
    rbc_settle_cycles = boost ? fast : slow;
  endfunction

endpackage

// ### testbench/tb_rbc_top.sv
// Purpose: Self-checking bench for the reference buffer control block.
// Assumes: APB answers one cycle after setup; settling takes 1000 or 250 cycles.
// Notes:   The driver queues each expected answer and a monitor retires it.
`timescale 1ns/1ps
`include "rbc_map.svh"

module tb_rbc_top
  import rbc_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        buf_enable;
  logic        bypass_switch_close;
  logic        hiz_enable;
  logic        boost_enable;
  logic        ref_isolate;
  logic        ref_ready;
  logic [31:0] r;
  logic [33:0] exp_q[$];
  integer      mismatches;
  integer      checks_done;
  integer      seed;
  integer      cyc = 0;
  integer      t_wr;
  wire  [5:0]  outs = {buf_enable, bypass_switch_close, hiz_enable, boost_enable,
                       ref_isolate, ref_ready};

  rbc_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
               .pready, .pslverr, .buf_enable, .bypass_switch_close, .hiz_enable,
               .boost_enable, .ref_isolate, .ref_ready);

  // A 100 ns clock for the 10 MHz system domain.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Free-running edge count used to time the settling wait from the enabling write.
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Each completed access retires the oldest note; writes only check the error flag.
  always @(posedge clk_sys) begin : mon
    logic [33:0] e;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[33]) cmp("prdata", e[32:1], prdata);
      cmp("pslverr", {31'h0, e[0]}, {31'h0, pslverr});
    end
  end

  // The request is held until pready is seen; release is left to the caller so that
  // back-to-back transfers keep psel high without a second assignment in one step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [31:0] ed, input logic ee);
    integer n;
    exp_q.push_back({w, ed, ee});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      results;
    end
  endtask

  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
    apb(1'b0, a, 32'h0, ed, ee);
    idle;
  endtask

  // Expected analog controls; the buffer wins over bypass so the switch never shorts it.
  function automatic logic [4:0] pins(input logic [3:0] c);
    return {c[0], c[1] & ~c[0], c[2], c[3] & c[0], c[0] | c[1]};
  endfunction

  task wr(input logic [31:0] d);
    apb(1'b1, 12'h000, d, 32'h0, 1'b0);
    t_wr = cyc;
    idle;
    @(posedge clk_sys);
    cmp("pins", {27'h0, pins(d[3:0])}, {27'h0, outs[5:1]});
  endtask

  // Ready is seen a fixed span after the enabling write's access edge: one edge to load
  // the wait, n edges of counting, and one edge for the bench to see the settled flag.
  task settle(input integer n);
    integer k;
    k = 0;
    while (ref_ready !== 1'b1 && k < 1100) begin
      @(posedge clk_sys);
      k++;
    end
    cmp("settle", n + 2, cyc - t_wr);
  endtask

  // Watchdog sized well above the longest settling wait.
  initial begin
    #(6000 * `RBC_CLK_NS);
    mismatches++;
    results;
  end

  // Main sequence.
  initial begin
    seed = 58821;
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp("outs", 32'h0, {26'h0, outs});
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    $display("test reset done");
    wr(32'h2);
    rd(12'h004, 32'h6, 1'b0);
    wr(32'h5);
    rd(12'h004, 32'h15, 1'b0);
    settle(1000);
    rd(12'h004, 32'hD, 1'b0);
    wr(32'h2);
    rd(12'h004, 32'h6, 1'b0);
    $display("test bypass and enable done");
    wr(32'hD);
    settle(250);
    apb(1'b0, 12'h000, 32'h0, 32'hD, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h004, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b1, 12'h00C, 32'hF, 32'h0, 1'b1);
    idle;
    rd(12'h000, 32'hD, 1'b0);
    rd(12'h004, 32'hD, 1'b0);
    $display("test boost and refusals done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp("outs", 32'h0, {26'h0, outs});
    rd(12'h000, 32'h0, 1'b0);
    wr(32'h1);
    rd(12'h004, 32'h35, 1'b0);
    wr(32'h3);
    $display("test second reset done");
    repeat (6) begin
      r = $random(seed);
      wr(r);
      rd(12'h000, {28'h0, r[3:0]}, 1'b0);
    end
    wr(32'h0);
    rd(12'h004, 32'h0, 1'b0);
    $display("test random and external done");
    results;
  end
endmodule // tb_rbc_top
